// ### rtl/ecs_pkg.sv
// Constants, types and carriers for the EEPROM command sequencer.
// Assumes a 16-bit processor bus with byte lanes and one 25 MHz clock.
// How it works
// - Verify command sets blank when array erased
// - Program command writes one buffered word
// - Sector erase clears the two-word sector
// - Mass erase needs disable and open bits
// - Sector modify erases sector then reprograms word
// - Early, misaligned, byte or busy array writes error
// - Second write or command before launch errors
// - Unknown command code errors in normal mode
// - Stray writes or zero to empty flag error
// - Register reads never disturb a sequence
// - Array reads while busy return invalid data
// - Access error locks the sequencer until cleared
// - Protected target or guarded mass erase violates
// - Protection violation locks until cleared
// - Stop aborts command, drops high voltage, flags
// - Stop exit sets empty flag, kills pending
// - Debug opens protection; secured special allows mass only
// - Reset aborts any command at once
// - Interrupt from enabled empty or complete flag
// - Writing one to empty flag launches command
// - Complete flag sets when all commands done
// - Command, address and data form two-stage buffer
package ecs_pkg;
  // ==========================================================
  // Bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int ARRAY_SEL = 15; // Address bit that selects the array
  // ==========================================================
  // Register offsets
  localparam logic [15:0] REG_CTRL = 16'h0000; // Interrupt enables
  localparam logic [15:0] REG_CLKDIV = 16'h0004; // Timing divider
  localparam logic [15:0] REG_PROT = 16'h0008; // Protection
  localparam logic [15:0] REG_STATUS = 16'h000C; // Status and launch
  localparam logic [15:0] REG_CMD = 16'h0010; // Command register
  // ==========================================================
  // Field positions
  localparam int CTRL_BE_IE = 0; // Buffer empty interrupt enable
  localparam int CTRL_CC_IE = 1; // Complete interrupt enable
  localparam int DIV_LOADED = 7; // Divider written since reset
  localparam int DIV_W = 6; // Divider field width
  localparam int PROT_OPEN = 0; // Protection open bit
  localparam int PROT_DIS = 1; // Protection disable bit
  localparam int ST_BE = 7; // Buffer empty flag
  localparam int ST_CC = 6; // Command complete flag
  localparam int ST_PV = 5; // Protection violation flag
  localparam int ST_AE = 4; // Access error flag
  localparam int ST_BLANK = 2; // Erased-verified flag
  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_VERIFY = 8'h05;
  localparam logic [7:0] CMD_PROG = 8'h20;
  localparam logic [7:0] CMD_SECT = 8'h40;
  localparam logic [7:0] CMD_MASS = 8'h41;
  localparam logic [7:0] CMD_MODIFY = 8'h60;
  // ==========================================================
  // Reset values and array timing in timebase ticks
  localparam logic [15:0] ERASED = 16'hFFFF; // Erased word value
  localparam logic [15:0] INVALID = 16'h0000; // Busy array read value
  localparam logic [7:0] PROT_RST = 8'h00; // Fully protected
  localparam int ERASE_TICKS = 20; // Erase pulse length
  localparam int PROG_TICKS = 6; // Program pulse length
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ECS_X_IDLE = 2'h0, ECS_X_ERASE = 2'h1,
    ECS_X_PROG = 2'h3, ECS_X_VERIFY = 2'h2
  } ecs_exec_e;
  typedef enum logic [1:0] {
    ECS_S_EMPTY = 2'h0, ECS_S_ADDR = 2'h1, ECS_S_CMD = 2'h3
  } ecs_seq_e;
  typedef struct packed {
    logic [7:0] cmd; // Command code
    logic [14:0] baddr; // Byte address in array
    logic [15:0] data; // Word to program
  } ecs_job_s;
endpackage : ecs_pkg

// ### rtl/ecs_sequencer.sv
// EEPROM command sequencer: command write checks, two-stage buffer,
// executing state machine with timebase and a small modelled array.
// Assumes a plain register port; mode pins come from another domain.
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module ecs_sequencer #(
  parameter int ARRAY_WORDS = 64 // Array size in 16-bit words
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [15:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic [1:0] BYTE_EN,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic STOP_MODE,
  input wire logic DEBUG_MODE,
  input wire logic SPECIAL_MODE,
  input wire logic SECURED,
  output logic IRQ,
  output logic HV_EN
);
  localparam int WI = $clog2(ARRAY_WORDS); // Word index width
  localparam logic [WI-1:0] LAST = WI'(ARRAY_WORDS - 1);
  localparam logic [4:0] ERASE_N = 5'(ecs_pkg::ERASE_TICKS - 1);
  localparam logic [4:0] PROG_N = 5'(ecs_pkg::PROG_TICKS - 1);
  // ==========================================================
  // Pin synchronisers, two flops each
  logic [3:0] pin_m_r; // First stage
  logic [3:0] pin_s_r; // Second stage
  logic stop_d_r; // Stop delayed for edge detection
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pin_m_r <= 4'h0;
      pin_s_r <= 4'h0;
      stop_d_r <= 1'b0;
    end else begin
      pin_m_r <= {SECURED, SPECIAL_MODE, DEBUG_MODE, STOP_MODE};
      pin_s_r <= pin_m_r;
      stop_d_r <= pin_s_r[0];
    end
  end
  logic stop_s, dbg_s, spec_s, sec_s; // Synchronised mode pins
  assign {sec_s, spec_s, dbg_s, stop_s} = pin_s_r;
  // ==========================================================
  // State
  logic [7:0] ctrl_r, ctrl_nxt; // Interrupt enables
  logic [5:0] div_r, div_nxt; // Timebase divider value
  logic div_ld_r, div_ld_nxt; // Divider written
  logic [7:0] prot_r, prot_nxt; // Protection bits
  logic be_r, be_nxt, cc_r, cc_nxt; // Empty and complete flags
  logic ae_r, ae_nxt, pv_r, pv_nxt; // Error flags
  logic blank_r, blank_nxt; // Erased-verified flag
  ecs_pkg::ecs_seq_e seq_r, seq_nxt; // Command write progress
  ecs_pkg::ecs_job_s buf_r, buf_nxt; // First buffer stage
  ecs_pkg::ecs_job_s pend_r, pend_nxt; // Launched, waiting
  logic pend_v_r, pend_v_nxt; // Pending stage holds a job
  ecs_pkg::ecs_job_s job_r, job_nxt; // Executing job
  ecs_pkg::ecs_exec_e x_r, x_nxt; // Execution state
  logic [5:0] dcnt_r, dcnt_nxt; // Divider counter
  logic [4:0] tcnt_r, tcnt_nxt; // Ticks in current pulse
  logic [WI-1:0] vcnt_r, vcnt_nxt; // Verify scan index
  logic vok_r, vok_nxt; // All scanned words erased
  logic [15:0] rdata_nxt;
  logic irq_nxt, hv_nxt;
  logic [15:0] mem [ARRAY_WORDS]; // Modelled array
  logic erase_all, erase_sec, prog_w; // Array operations
  // ==========================================================
  // Decode helpers
  logic arr_acc, reg_wr, st_wr, cmd_wr, locked, prot_any;
  logic launch, tick, stop_rise, stop_fall, code_ok;
  logic [WI-1:0] jidx; // Word index of executing job
  assign arr_acc = ADDR[ecs_pkg::ARRAY_SEL];
  assign reg_wr = WR && !arr_acc;
  assign st_wr = reg_wr && ADDR == ecs_pkg::REG_STATUS;
  assign cmd_wr = reg_wr && ADDR == ecs_pkg::REG_CMD;
  assign locked = ae_r || pv_r;
  // Any protection active unless both disable and open are set
  assign prot_any = !(prot_r[ecs_pkg::PROT_DIS]
                      && prot_r[ecs_pkg::PROT_OPEN]);
  assign launch = st_wr && seq_r == ecs_pkg::ECS_S_CMD
                  && WDATA[ecs_pkg::ST_BE] && !locked;
  assign tick = div_ld_r && dcnt_r == div_r;
  assign stop_rise = stop_s && !stop_d_r;
  assign stop_fall = !stop_s && stop_d_r;
  assign code_ok = WDATA[7:0] inside {ecs_pkg::CMD_VERIFY, ecs_pkg::CMD_PROG,
    ecs_pkg::CMD_SECT, ecs_pkg::CMD_MASS, ecs_pkg::CMD_MODIFY};
  assign jidx = job_r.baddr[WI:1];
  // ==========================================================
  // Command write sequence, flags and registers
  always_comb begin
    ctrl_nxt = ctrl_r;
    div_nxt = div_r;
    div_ld_nxt = div_ld_r;
    prot_nxt = prot_r;
    be_nxt = be_r;
    cc_nxt = cc_r;
    ae_nxt = ae_r;
    pv_nxt = pv_r;
    blank_nxt = blank_r;
    seq_nxt = seq_r;
    buf_nxt = buf_r;
    pend_nxt = pend_r;
    pend_v_nxt = pend_v_r;
    // Clear-on-one of error flags; sets below win
    if (st_wr && seq_r == ecs_pkg::ECS_S_EMPTY) begin
      if (WDATA[ecs_pkg::ST_AE]) ae_nxt = 1'b0;
      if (WDATA[ecs_pkg::ST_PV]) pv_nxt = 1'b0;
    end
    if (WR && arr_acc) begin
      // Array write opens a sequence
      if (!div_ld_r || BYTE_EN != 2'h3 || ADDR[0] || !be_r
          || seq_r != ecs_pkg::ECS_S_EMPTY || locked) begin
        ae_nxt = 1'b1;
        seq_nxt = ecs_pkg::ECS_S_EMPTY;
      end else if (prot_any && ADDR[WI]) begin
        pv_nxt = 1'b1; // Upper half guarded
      end else begin
        buf_nxt.baddr = ADDR[14:0];
        buf_nxt.data = WDATA;
        seq_nxt = ecs_pkg::ECS_S_ADDR;
      end
    end else if (cmd_wr && seq_r == ecs_pkg::ECS_S_ADDR) begin
      if (!code_ok && !spec_s) begin
        ae_nxt = 1'b1;
        seq_nxt = ecs_pkg::ECS_S_EMPTY;
      end else if (spec_s && sec_s
                   && WDATA[7:0] != ecs_pkg::CMD_MASS) begin
        ae_nxt = 1'b1; // Secured: mass erase only
        seq_nxt = ecs_pkg::ECS_S_EMPTY;
      end else if (WDATA[7:0] == ecs_pkg::CMD_MASS && prot_any) begin
        pv_nxt = 1'b1;
        seq_nxt = ecs_pkg::ECS_S_EMPTY;
      end else begin
        buf_nxt.cmd = WDATA[7:0];
        seq_nxt = ecs_pkg::ECS_S_CMD;
      end
    end else if (launch) begin
      // Move first stage into pending stage
      pend_nxt = buf_r;
      pend_v_nxt = 1'b1;
      be_nxt = 1'b0;
      cc_nxt = 1'b0;
      blank_nxt = 1'b0;
      seq_nxt = ecs_pkg::ECS_S_EMPTY;
    end else if (reg_wr && seq_r != ecs_pkg::ECS_S_EMPTY) begin
      // Other register write, second command or zero launch bit
      ae_nxt = 1'b1;
      seq_nxt = ecs_pkg::ECS_S_EMPTY;
    end else if (reg_wr) begin
      // Plain configuration writes outside a sequence
      if (ADDR == ecs_pkg::REG_CTRL) ctrl_nxt = WDATA[7:0];
      if (ADDR == ecs_pkg::REG_CLKDIV) begin
        div_nxt = WDATA[ecs_pkg::DIV_W-1:0];
        div_ld_nxt = 1'b1;
      end
      if (ADDR == ecs_pkg::REG_PROT && dbg_s)
        prot_nxt = WDATA[7:0];
    end
    // Pending job moves to execution, buffer empties
    if (pend_v_r && x_r == ecs_pkg::ECS_X_IDLE && !stop_s) begin
      pend_v_nxt = 1'b0;
      be_nxt = 1'b1;
      if (x_nxt == ecs_pkg::ECS_X_IDLE) cc_nxt = 1'b1; // No-op done
    end
    // Done only when nothing executes nor waits
    if (x_r != ecs_pkg::ECS_X_IDLE && x_nxt == ecs_pkg::ECS_X_IDLE
        && !pend_v_r && !launch)
      cc_nxt = 1'b1;
    if (x_r == ecs_pkg::ECS_X_VERIFY && vcnt_r == LAST)
      blank_nxt = vok_r && mem[vcnt_r] == ecs_pkg::ERASED;
    // Stop entry while busy drops the pending job, sets cc and ae
    if (stop_rise && !cc_r) begin
      pend_v_nxt = 1'b0;
      cc_nxt = 1'b1;
      ae_nxt = 1'b1;
    end
    // Stop exit kills pending command
    if (stop_fall) begin
      pend_v_nxt = 1'b0;
      be_nxt = 1'b1;
      seq_nxt = ecs_pkg::ECS_S_EMPTY;
    end
  end
  // ==========================================================
  // Execution state machine
  always_comb begin
    x_nxt = x_r;
    job_nxt = job_r;
    tcnt_nxt = tcnt_r;
    vcnt_nxt = vcnt_r;
    vok_nxt = vok_r;
    dcnt_nxt = tick ? 6'h00 : dcnt_r + 6'h01;
    erase_all = 1'b0;
    erase_sec = 1'b0;
    prog_w = 1'b0;
    case (x_r)
      ecs_pkg::ECS_X_IDLE: begin
        if (pend_v_r && !stop_s) begin
          job_nxt = pend_r;
          tcnt_nxt = 5'h00;
          vcnt_nxt = '0;
          vok_nxt = 1'b1;
          case (pend_r.cmd)
            ecs_pkg::CMD_VERIFY: x_nxt = ecs_pkg::ECS_X_VERIFY;
            ecs_pkg::CMD_PROG: x_nxt = ecs_pkg::ECS_X_PROG;
            ecs_pkg::CMD_SECT, ecs_pkg::CMD_MASS,
            ecs_pkg::CMD_MODIFY: x_nxt = ecs_pkg::ECS_X_ERASE;
            default: x_nxt = ecs_pkg::ECS_X_IDLE; // Special no-op
          endcase
        end
      end
      ecs_pkg::ECS_X_ERASE: begin
        if (tick) tcnt_nxt = tcnt_r + 5'h01;
        if (tick && tcnt_r == ERASE_N) begin
          erase_all = job_r.cmd == ecs_pkg::CMD_MASS;
          erase_sec = !erase_all;
          tcnt_nxt = 5'h00;
          x_nxt = job_r.cmd == ecs_pkg::CMD_MODIFY
                  ? ecs_pkg::ECS_X_PROG : ecs_pkg::ECS_X_IDLE;
        end
      end
      ecs_pkg::ECS_X_PROG: begin
        if (tick) tcnt_nxt = tcnt_r + 5'h01;
        if (tick && tcnt_r == PROG_N) begin
          prog_w = 1'b1;
          x_nxt = ecs_pkg::ECS_X_IDLE;
        end
      end
      ecs_pkg::ECS_X_VERIFY: begin
        // One word per clock over the whole array
        vok_nxt = vok_r && mem[vcnt_r] == ecs_pkg::ERASED;
        vcnt_nxt = vcnt_r + WI'(1);
        if (vcnt_r == LAST) x_nxt = ecs_pkg::ECS_X_IDLE;
      end
      default: x_nxt = ecs_pkg::ECS_X_IDLE;
    endcase
    // Stop entry drops the active command
    if (stop_rise) begin
      x_nxt = ecs_pkg::ECS_X_IDLE;
      erase_all = 1'b0;
      erase_sec = 1'b0;
      prog_w = 1'b0;
    end
  end
  // ==========================================================
  // Outputs: read data, interrupt, high voltage
  always_comb begin
    rdata_nxt = 16'h0000;
    if (RD && arr_acc)
      rdata_nxt = cc_r ? mem[ADDR[WI:1]] : ecs_pkg::INVALID;
    else if (RD) begin
      // Reads have no side effects
      case (ADDR)
        ecs_pkg::REG_CTRL: rdata_nxt = {8'h00, ctrl_r};
        ecs_pkg::REG_CLKDIV: rdata_nxt = {8'h00, div_ld_r, 1'b0, div_r};
        ecs_pkg::REG_PROT: rdata_nxt = {8'h00, prot_r};
        ecs_pkg::REG_STATUS: rdata_nxt = {8'h00, be_r, cc_r, pv_r, ae_r,
                                          1'b0, blank_r, 2'h0};
        ecs_pkg::REG_CMD: rdata_nxt = {8'h00, buf_r.cmd};
        default: rdata_nxt = 16'h0000;
      endcase
    end
    irq_nxt = (be_nxt && ctrl_nxt[ecs_pkg::CTRL_BE_IE])
              || (cc_nxt && ctrl_nxt[ecs_pkg::CTRL_CC_IE]);
    hv_nxt = x_nxt inside {ecs_pkg::ECS_X_ERASE, ecs_pkg::ECS_X_PROG};
  end
  // ==========================================================
  // Register all state; reset aborts any command
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ctrl_r <= 8'h00;
      div_r <= 6'h00;
      div_ld_r <= 1'b0;
      prot_r <= ecs_pkg::PROT_RST;
      be_r <= 1'b1;
      cc_r <= 1'b1;
      ae_r <= 1'b0;
      pv_r <= 1'b0;
      blank_r <= 1'b0;
      seq_r <= ecs_pkg::ECS_S_EMPTY;
      buf_r <= '0;
      pend_r <= '0;
      pend_v_r <= 1'b0;
      job_r <= '0;
      x_r <= ecs_pkg::ECS_X_IDLE;
      dcnt_r <= 6'h00;
      tcnt_r <= 5'h00;
      vcnt_r <= '0;
      vok_r <= 1'b0;
      RDATA <= 16'h0000;
      IRQ <= 1'b0;
      HV_EN <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      div_r <= div_nxt;
      div_ld_r <= div_ld_nxt;
      prot_r <= prot_nxt;
      be_r <= be_nxt;
      cc_r <= cc_nxt;
      ae_r <= ae_nxt;
      pv_r <= pv_nxt;
      blank_r <= blank_nxt;
      seq_r <= seq_nxt;
      buf_r <= buf_nxt;
      pend_r <= pend_nxt;
      pend_v_r <= pend_v_nxt;
      job_r <= job_nxt;
      x_r <= x_nxt;
      dcnt_r <= dcnt_nxt;
      tcnt_r <= tcnt_nxt;
      vcnt_r <= vcnt_nxt;
      vok_r <= vok_nxt;
      RDATA <= rdata_nxt;
      IRQ <= irq_nxt;
      HV_EN <= hv_nxt;
    end
  end
  // ==========================================================
  // Array words, one generate entry per word
  for (genvar w = 0; w < ARRAY_WORDS; w++) begin : g_word
    localparam logic [WI-1:0] WIDX = WI'(w); // This entry's index
    always_ff @(posedge SYS_CLK) begin
      if (erase_all || (erase_sec && jidx[WI-1:1] == WIDX[WI-1:1]))
        mem[w] <= ecs_pkg::ERASED;
      else if (prog_w && jidx == WIDX)
        mem[w] <= job_r.data;
    end
  end
  // ==========================================================
  // Assertions
  launch_clears_cc_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_N) launch && !stop_s |=> !cc_r && !be_r)
    else $error("launch did not clear complete and empty");
  bad_code_ae_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_N) cmd_wr && seq_r == ecs_pkg::ECS_S_ADDR
    && !code_ok && !spec_s |=> ae_r && seq_r == ecs_pkg::ECS_S_EMPTY)
    else $error("invalid command not flagged");
  zero_launch_ae_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_N) st_wr && seq_r == ecs_pkg::ECS_S_CMD
    && !WDATA[ecs_pkg::ST_BE] |=> ae_r && !pend_v_r)
    else $error("zero to empty flag did not abort");
  mass_guard_pv_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_N) cmd_wr && seq_r == ecs_pkg::ECS_S_ADDR
    && WDATA[7:0] == ecs_pkg::CMD_MASS && prot_any && !ae_r
    && !(spec_s && !sec_s && !code_ok) |=> pv_r)
    else $error("guarded mass erase not flagged");
  lock_holds_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_N) locked && cc_r && !stop_rise
    |=> cc_r [*2])
    else $error("locked sequencer launched a command");
  stop_abort_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_N) stop_rise && !cc_r
    |=> cc_r && ae_r && x_r == ecs_pkg::ECS_X_IDLE ##1 !HV_EN)
    else $error("stop entry did not abort");
  read_quiet_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_N) RD && !ae_r && !stop_rise |=> !ae_r)
    else $error("register read set access error");
  busy_read_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_N) RD && arr_acc && !cc_r
    |=> RDATA == ecs_pkg::INVALID)
    else $error("busy array read returned data");
  done_idle_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_N) $rose(cc_r)
    |-> x_r == ecs_pkg::ECS_X_IDLE && !pend_v_r)
    else $error("complete set with work outstanding");
  early_write_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_N) WR && arr_acc && !div_ld_r |=> ae_r)
    else $error("array write before divider not flagged");
  lock_refuse_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_N) locked && WR && arr_acc
    |=> ae_r && seq_r == ecs_pkg::ECS_S_EMPTY)
    else $error("locked sequencer accepted an array write");
  launch_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
    launch ##[1:400] $rose(cc_r));
  blank_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
    $rose(blank_r));
  modify_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
    x_r == ecs_pkg::ECS_X_ERASE ##1 x_r == ecs_pkg::ECS_X_PROG);
endmodule : ecs_sequencer
`default_nettype wire

// ### tb/ecs_host.sv
// Host processor model: drives the register port of the sequencer.
// Assumes one bench clock and one access at a time, strobes one cycle.
`timescale 1ns/10ps
`default_nettype none
module ecs_host (
  input wire logic clk,
  output logic [15:0] addr,
  output logic [15:0] wdata,
  output logic [1:0] byte_en,
  output logic wr,
  output logic rd,
  input wire logic [15:0] rdata
);
  // ==========================================================
  // Idle bus at time zero
  initial begin
    addr = 16'h0000;
    wdata = 16'h0000;
    byte_en = 2'b11;
    wr = 1'b0;
    rd = 1'b0;
  end
  // ==========================================================
  // One write cycle, held until the sampling edge
  task automatic put(input logic [15:0] a, input logic [15:0] d,
    input logic [1:0] b);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    byte_en <= b;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : put
  // One read cycle; data stands only in the cycle after
  task automatic get(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : get
  // Full three-step sequence; launch writes one to the empty flag
  task automatic seq(input logic [15:0] a, input logic [15:0] d,
    input logic [7:0] c);
    put(a, d, 2'b11);
    put(ecs_pkg::REG_CMD, {8'h00, c}, 2'b11);
    put(ecs_pkg::REG_STATUS, 16'h0080, 2'b11);
  endtask : seq
endmodule : ecs_host
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the EEPROM command sequencer.
// Assumes the host model of ecs_host.sv and a 25 MHz system clock.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk, rst_n, stop_m, dbg_m, irq, hv, wr, rd;
  logic spec_m, sec_m; // Special and secured mode pins
  logic [15:0] addr, wdata, rdata, v;
  logic [1:0] ben;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  localparam logic [15:0] ST = ecs_pkg::REG_STATUS;
  localparam logic [15:0] CM = ecs_pkg::REG_CMD;
  // ==========================================================
  // Clock, hang guard and instances
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  ecs_sequencer ecs_sequencer_inst (.SYS_CLK(clk), .RST_N(rst_n),
    .ADDR(addr), .WDATA(wdata), .BYTE_EN(ben), .WR(wr), .RD(rd),
    .RDATA(rdata), .STOP_MODE(stop_m), .DEBUG_MODE(dbg_m),
    .SPECIAL_MODE(spec_m), .SECURED(sec_m), .IRQ(irq), .HV_EN(hv));
  ecs_host ecs_host_inst (.clk(clk), .addr(addr), .wdata(wdata),
    .byte_en(ben), .wr(wr), .rd(rd), .rdata(rdata));
  // ==========================================================
  // Shared helpers
  task automatic check(input string n, input logic [15:0] s,
    input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic w(input logic [15:0] a, input logic [15:0] d);
    ecs_host_inst.put(a, d, 2'b11);
  endtask : w
  task automatic rchk(input string n, input logic [15:0] a,
    input logic [15:0] e);
    ecs_host_inst.get(a, v);
    check(n, v, e);
  endtask : rchk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wait_done();
    for (int i = 0; i < 200; i++) begin
      ecs_host_inst.get(ST, v);
      if (v[6] === 1'b1) return;
    end
    check("complete", v, 16'h00C0);
  endtask : wait_done
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rchk("status", ST, 16'h00C0);
    w(16'h8000, 16'h0000);
    rchk("early", ST, 16'h00D0);
    w(ST, 16'h0030);
    w(ecs_pkg::REG_PROT, 16'h0003);
    rchk("prot lock", ecs_pkg::REG_PROT, 16'h0000);
    w(ecs_pkg::REG_CLKDIV, 16'h0000);
    dbg_m <= 1'b1;
    cyc(4);
    w(ecs_pkg::REG_PROT, 16'h0003);
    rchk("prot dbg", ecs_pkg::REG_PROT, 16'h0003);
    $display("reset scenario done");
  endtask : t_reset
  task automatic t_flow();
    ecs_host_inst.seq(16'h8000, 16'h0000, ecs_pkg::CMD_MASS);
    rchk("busy read", 16'h8000, ecs_pkg::INVALID);
    wait_done();
    ecs_host_inst.seq(16'h8000, 16'h0000, ecs_pkg::CMD_VERIFY);
    wait_done();
    rchk("blank", ST, 16'h00C4);
    w(16'h8000, 16'h1234);
    ecs_host_inst.get(ecs_pkg::REG_CTRL, v);
    w(CM, {8'h00, ecs_pkg::CMD_PROG});
    w(ST, 16'h0080);
    wait_done();
    rchk("no error", ST, 16'h00C0);
    rchk("program", 16'h8000, 16'h1234);
    ecs_host_inst.seq(16'h8002, 16'h0000, ecs_pkg::CMD_SECT);
    wait_done();
    rchk("sector", 16'h8000, 16'hFFFF);
    ecs_host_inst.seq(16'h8000, 16'h5A5A, ecs_pkg::CMD_MODIFY);
    cyc(2);
    // Sector was erased by the modify
    ecs_host_inst.seq(16'h8002, 16'hA5A5, ecs_pkg::CMD_PROG);
    ecs_host_inst.get(ST, v);
    check("pending", v & 16'h0040, 16'h0000);
    wait_done();
    rchk("modify", 16'h8000, 16'h5A5A);
    rchk("pipelined", 16'h8002, 16'hA5A5);
    ecs_host_inst.seq(16'h8000, 16'h0000, ecs_pkg::CMD_VERIFY);
    wait_done();
    rchk("not blank", ST, 16'h00C0);
    $display("flow scenario done");
  endtask : t_flow
  task automatic t_errors();
    for (int k = 0; k < 6; k++) begin
      ecs_host_inst.put(k == 0 ? 16'h8001 : 16'h8000, 16'h1111,
        k == 1 ? 2'b01 : 2'b11);
      case (k)
        2: w(16'h8004, 16'h1111);
        3: w(CM, 16'h0033);
        4: begin
          w(CM, {8'h00, ecs_pkg::CMD_PROG});
          w(CM, {8'h00, ecs_pkg::CMD_PROG});
        end
        5: begin
          w(CM, {8'h00, ecs_pkg::CMD_PROG});
          w(ST, 16'h0000);
        end
        default: ;
      endcase
      rchk("error", ST, 16'h00D0);
      if (k == 5) begin
        ecs_host_inst.seq(16'h8000, 16'h7777, ecs_pkg::CMD_PROG);
        wait_done();
        rchk("ae lock", 16'h8000, 16'h5A5A);
      end
      w(ST, 16'h0030);
    end
    rchk("cleared", ST, 16'h00C0);
    $display("error scenario done");
  endtask : t_errors
  task automatic t_prot();
    w(ecs_pkg::REG_PROT, 16'h0000);
    w(16'h8040, 16'h2222);
    rchk("violation", ST, 16'h00E0);
    ecs_host_inst.seq(16'h8000, 16'h3333, ecs_pkg::CMD_PROG);
    rchk("pv lock", 16'h8000, 16'h5A5A);
    w(ST, 16'h0030);
    w(16'h8000, 16'h0000);
    w(CM, {8'h00, ecs_pkg::CMD_MASS});
    rchk("mass guard", ST, 16'h00E0);
    w(ST, 16'h0030);
    w(ecs_pkg::REG_PROT, 16'h0003);
    $display("protection scenario done");
  endtask : t_prot
  task automatic t_secure();
    spec_m <= 1'b1;
    sec_m <= 1'b1;
    cyc(4);
    ecs_host_inst.seq(16'h8000, 16'h0000, ecs_pkg::CMD_PROG);
    rchk("secured prog", ST, 16'h00D0);
    w(ST, 16'h0030);
    ecs_host_inst.seq(16'h8000, 16'h0000, ecs_pkg::CMD_MASS);
    wait_done();
    rchk("secured mass", 16'h8000, ecs_pkg::ERASED);
    @(posedge clk);
    sec_m <= 1'b0;
    cyc(4);
    // Unknown code in special mode runs as a no-op
    ecs_host_inst.seq(16'h8000, 16'h0000, 8'h33);
    wait_done();
    rchk("special noop", ST, 16'h00C0);
    @(posedge clk);
    spec_m <= 1'b0;
    cyc(4);
    $display("secured scenario done");
  endtask : t_secure
  task automatic t_irq();
    w(ecs_pkg::REG_CTRL, 16'h0001);
    cyc(3);
    check("irq empty", {15'h0000, irq}, 16'h0001);
    w(ecs_pkg::REG_CTRL, 16'h0002);
    ecs_host_inst.seq(16'h8004, 16'h0000, ecs_pkg::CMD_SECT);
    cyc(3);
    check("irq busy", {15'h0000, irq}, 16'h0000);
    wait_done();
    cyc(2);
    check("irq done", {15'h0000, irq}, 16'h0001);
    w(ecs_pkg::REG_CTRL, 16'h0000);
    cyc(3);
    check("irq off", {15'h0000, irq}, 16'h0000);
    $display("interrupt scenario done");
  endtask : t_irq
  task automatic t_stop();
    // Stop during an erase on purpose
    ecs_host_inst.seq(16'h8000, 16'h0000, ecs_pkg::CMD_SECT);
    cyc(3);
    check("hv on", {15'h0000, hv}, 16'h0001);
    @(posedge clk);
    stop_m <= 1'b1;
    cyc(6);
    check("hv off", {15'h0000, hv}, 16'h0000);
    rchk("stop flags", ST, 16'h00D0);
    @(posedge clk);
    stop_m <= 1'b0;
    cyc(6);
    rchk("stop exit", ST, 16'h00D0);
    w(ST, 16'h0030);
    ecs_host_inst.seq(16'h8000, 16'h0000, ecs_pkg::CMD_SECT);
    cyc(3);
    @(posedge clk);
    rst_n <= 1'b0;
    cyc(2);
    check("hv reset", {15'h0000, hv}, 16'h0000);
    @(posedge clk);
    rst_n <= 1'b1;
    rchk("after reset", ST, 16'h00C0);
    $display("stop and reset scenario done");
  endtask : t_stop
  // ==========================================================
  // Verdict and main sequence
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    rst_n = 1'b0;
    stop_m = 1'b0;
    dbg_m = 1'b0;
    spec_m = 1'b0;
    sec_m = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_flow();
    t_errors();
    t_prot();
    t_secure();
    t_irq();
    t_stop();
    complete_run();
  end
endmodule : tb
`default_nettype wire
